/* src/lsb_consts.svh */
// Operation
// - The array holds 512 bytes as 128 words of 32 bits.
// - A request that hits is answered one cycle after it is taken.
// - Byte, word and longword writes use their own byte lanes; reads return the whole longword.
// - The base may sit at any 512-byte aligned address.
// - Core and debug requests share the one local request port.
// - A hitting fetch is served here and the cache result is dropped.
// - Data served here is marked as never to be cached.
// - Register code C04 writes in supervisor mode, reads only in debug state.
// - Reserved register bits ignore writes and read as zero.
// - A read outside debug state returns zero.
// - Reset clears the valid bit; array contents stay undefined.
// - Base bits 31 to 9 are compared with address bits 31 to 9.
// - With write protect set, a hitting write stores nothing and errors.
// - A set space mask sends that space's requests to the external bus.
// - With valid clear, matching requests go to the external bus.
// - Mapped only if valid, address matches and the space mask is clear.
// - Both code masks idle the array on fetches; both data masks on operands.
`ifndef LSB_CONSTS_SVH
`define LSB_CONSTS_SVH
`define LSB_MEM_BYTES 512
`define LSB_MEM_WORDS 128
`define LSB_WORD_BITS 32
`define LSB_WORD_AW 7
`define LSB_CTL_CODE 12'hC04
`define LSB_VALID_BIT 0
`define LSB_UD_BIT 1
`define LSB_UC_BIT 2
`define LSB_SD_BIT 3
`define LSB_SC_BIT 4
`define LSB_CI_BIT 5
`define LSB_WP_BIT 8
`define LSB_BA_LO 9
`define LSB_BA_HI 31
`define LSB_WR_MASK 32'hFFFF_FF3F
`define LSB_RESET_VAL 32'h0000_0000
`define LSB_SIZE_LONG 2'h0
`define LSB_SIZE_BYTE 2'h1
`define LSB_SIZE_WORD 2'h2
`define LSB_SIZE_LINE 2'h3
`define LSB_TT_NORMAL 2'h0
`define LSB_TT_RSVD 2'h1
`define LSB_TT_DEBUG 2'h2
`define LSB_TT_CPU 2'h3
`endif

/* src/lsb_pkg.sv */
package lsb_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic [1:0] size;
    logic [1:0] tt;
    logic superMode;
    logic code;
  } lsb_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic discard;
    logic noAlloc;
    logic [31:0] rdata;
  } lsb_resp_t;
endpackage

/* src/lsb_space_decode.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lsb_consts.svh"
module lsb_space_decode (
  input wire logic [1:0] tt,
  input wire logic superMode,
  input wire logic code,
  input wire logic [4:0] maskBits,
  output logic spaceMasked,
  output logic isFetch
);
  // maskBits: 0 user data, 1 user code, 2 supervisor data, 3 supervisor code, 4 cpu space
  always_comb
  begin
    spaceMasked = 1'b1;
    isFetch = 1'b0;
    case (tt)
      `LSB_TT_NORMAL:
      begin
        isFetch = code;
        spaceMasked = maskBits[{superMode, code}];
      end
      `LSB_TT_DEBUG:
      begin
        isFetch = code;
        spaceMasked = maskBits[{1'b1, code}];
      end
      `LSB_TT_CPU:
      begin
        spaceMasked = maskBits[4];
      end
      default:
      begin
        spaceMasked = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

/* src/lsb_sram_array.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lsb_consts.svh"
module lsb_sram_array #(
  parameter int DEPTH = `LSB_MEM_WORDS,
  parameter int WIDTH = `LSB_WORD_BITS,
  parameter int AW = `LSB_WORD_AW
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [WIDTH/8-1:0] byteEn,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Byte lane writes
  always_ff @(posedge clk)
  begin
    if (ce && wrEn)
    begin
      for (int i = 0; i < WIDTH / 8; i++)
      begin
        if (byteEn[i])
        begin
          mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
    end
  end

  // Registered read, idle unless enabled
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata <= '0;
    end
    else if (ce && rdEn)
    begin
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

/* src/lsb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lsb_consts.svh"
module lsb_top
  import lsb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic reqValid,
  input wire lsb_req_t req,
  input wire logic ctlWrEn,
  input wire logic ctlRdEn,
  input wire logic [11:0] ctlCode,
  input wire logic [31:0] ctlWdata,
  input wire logic ctlSuper,
  input wire logic debugMode,
  output lsb_resp_t resp,
  output logic extValid,
  output lsb_req_t extReq,
  output logic [31:0] ctlRdata,
  output logic ctlRdValid
);
  logic [31:0] baseReg_r;
  logic [31:0] baseReg_nxt;
  logic done_r;
  logic err_r;
  logic discard_r;
  logic noAlloc_r;
  logic [31:0] memRdata;
  logic extValid_r;
  lsb_req_t extReq_r;
  logic [31:0] ctlRdata_r;
  logic ctlRdValid_r;

  logic validBit;
  logic wpBit;
  logic [4:0] maskBits;
  logic addrMatch;
  logic spaceMasked;
  logic isFetch;
  logic hitMap;
  logic codeIdle;
  logic dataIdle;
  logic arrayIdle;
  logic memRe;
  logic memWe;
  logic [3:0] byteEn;
  logic regWrite;
  logic regRead;

  // Byte lanes, big-endian: address byte 0 is bits 31:24
  function automatic logic [3:0] laneSel(input logic [1:0] size, input logic [1:0] low);
    logic [3:0] sel;
    sel = 4'hF;
    case (size)
      `LSB_SIZE_BYTE:
      begin
        sel = 4'h8 >> low;
      end
      `LSB_SIZE_WORD:
      begin
        sel = low[1] ? 4'h3 : 4'hC;
      end
      `LSB_SIZE_LONG:
      begin
        sel = 4'hF;
      end
      default:
      begin
        sel = 4'hF;
      end
    endcase
    return sel;
  endfunction

  // Register fields
  assign validBit = baseReg_r[`LSB_VALID_BIT];
  assign wpBit = baseReg_r[`LSB_WP_BIT];
  assign maskBits = baseReg_r[`LSB_CI_BIT:`LSB_UD_BIT];

  // Space decode for core and debug requests alike
  lsb_space_decode uDecode (
    .tt(req.tt),
    .superMode(req.superMode),
    .code(req.code),
    .maskBits(maskBits),
    .spaceMasked(spaceMasked),
    .isFetch(isFetch)
  );

  // Hit decision in the request cycle
  assign addrMatch = req.addr[`LSB_BA_HI:`LSB_BA_LO] ==
                     baseReg_r[`LSB_BA_HI:`LSB_BA_LO];
  assign hitMap = validBit && addrMatch && !spaceMasked;

  // Power saving when a whole class of accesses is masked
  assign codeIdle = baseReg_r[`LSB_SC_BIT] && baseReg_r[`LSB_UC_BIT];
  assign dataIdle = baseReg_r[`LSB_SD_BIT] && baseReg_r[`LSB_UD_BIT];
  // CPU space has its own mask, so class masks must not idle it
  assign arrayIdle = (req.tt != `LSB_TT_CPU) && (isFetch ? codeIdle : dataIdle);

  assign byteEn = laneSel(req.size, req.addr[1:0]);
  assign memRe = reqValid && hitMap && !req.write && !arrayIdle;
  assign memWe = reqValid && hitMap && req.write && !wpBit && !arrayIdle;

  lsb_sram_array #(
    .DEPTH(`LSB_MEM_WORDS),
    .WIDTH(`LSB_WORD_BITS),
    .AW(`LSB_WORD_AW)
  ) uArray (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .rdEn(memRe),
    .wrEn(memWe),
    .byteEn(byteEn),
    .addr(req.addr[8:2]),
    .wdata(req.wdata),
    .rdata(memRdata)
  );

  // Control register move access
  assign regWrite = ctlWrEn && (ctlCode == `LSB_CTL_CODE) && (ctlSuper || debugMode);
  assign regRead = ctlRdEn && (ctlCode == `LSB_CTL_CODE);
  assign baseReg_nxt = ctlWdata & `LSB_WR_MASK;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      baseReg_r <= `LSB_RESET_VAL;
    end
    else if (ce && regWrite)
    begin
      baseReg_r <= baseReg_nxt;
    end
  end

  // Read back, visible only in debug state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctlRdata_r <= '0;
      ctlRdValid_r <= 1'b0;
    end
    else if (ce)
    begin
      ctlRdValid_r <= regRead;
      if (regRead && debugMode)
      begin
        ctlRdata_r <= baseReg_r;
      end
      else
      begin
        ctlRdata_r <= '0;
      end
    end
  end

  // Local answer for mapped requests
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      discard_r <= 1'b0;
      noAlloc_r <= 1'b0;
    end
    else if (ce)
    begin
      done_r <= reqValid && hitMap;
      err_r <= reqValid && hitMap && req.write && wpBit;
      discard_r <= reqValid && hitMap && !req.write && isFetch;
      noAlloc_r <= reqValid && hitMap;
    end
  end

  // Forward non-mapped requests to the external bus controller
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      extValid_r <= 1'b0;
      extReq_r <= '0;
    end
    else if (ce)
    begin
      extValid_r <= reqValid && !hitMap;
      if (reqValid && !hitMap)
      begin
        extReq_r <= req;
      end
    end
  end

  assign resp = '{done: done_r, err: err_r, discard: discard_r,
                  noAlloc: noAlloc_r, rdata: memRdata};
  assign extValid = extValid_r;
  assign extReq = extReq_r;
  assign ctlRdata = ctlRdata_r;
  assign ctlRdValid = ctlRdValid_r;

  // Checks
  chk_single_cycle: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && reqValid && hitMap |=> resp.done && !extValid)
    else $error("mapped request not answered in one cycle");

  chk_wp_error: assert property (
    @(posedge clk) disable iff (sys_rst)
    reqValid && hitMap && req.write && wpBit |-> !memWe ##1 (resp.err || !$past(ce)))
    else $error("protected write stored or gave no error");

  chk_miss_forward: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && reqValid && !hitMap |=> extValid && !resp.done && extReq == $past(req))
    else $error("miss not forwarded next cycle");

  chk_invalid_bypass: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && reqValid && !validBit && addrMatch |=> extValid && !resp.done)
    else $error("access served while valid bit clear");

  chk_mask_bypass: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && reqValid && spaceMasked |=> !resp.done && !resp.err && extValid)
    else $error("masked space reached the array");

  chk_fetch_discard: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && reqValid && hitMap && isFetch && !req.write |=> resp.discard && resp.noAlloc)
    else $error("hitting fetch did not drop cache result");

  chk_readback_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && ctlRdEn && !debugMode |=> ctlRdata == 32'h0000_0000)
    else $error("register readable outside debug state");

  chk_reg_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && regWrite |=> baseReg_r == ($past(ctlWdata) & 32'hFFFF_FF3F) && baseReg_r[7:6] == 2'h0)
    else $error("register write wrong or reserved bits kept");

  chk_reset_valid: assert property (
    @(posedge clk)
    $past(sys_rst) |-> !validBit && !resp.done)
    else $error("valid bit set after reset");

  chk_power_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    reqValid && isFetch && codeIdle |-> !memRe && !memWe)
    else $error("array active on fetch with code masked");

  chk_byte_lane: assert property (
    @(posedge clk) disable iff (sys_rst)
    memWe && req.size == `LSB_SIZE_BYTE |-> $onehot(byteEn))
    else $error("byte write touched more than one lane");

  chk_done_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && !reqValid |=> !resp.done && !extValid)
    else $error("answer given without a request");

  chk_one_answer: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(resp.done && extValid))
    else $error("request both answered and forwarded");

  chk_err_done: assert property (
    @(posedge clk) disable iff (sys_rst)
    resp.err |-> resp.done)
    else $error("access error without answer");

  chk_discard_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    resp.discard |-> resp.done && resp.noAlloc && !resp.err)
    else $error("cache drop outside a hitting read");

  chk_no_alloc: assert property (
    @(posedge clk) disable iff (sys_rst)
    resp.done |-> resp.noAlloc)
    else $error("local answer not marked uncached");

  chk_wp_no_store: assert property (
    @(posedge clk) disable iff (sys_rst)
    reqValid && wpBit |-> !memWe)
    else $error("array written while protected");

  chk_store_open: assert property (
    @(posedge clk) disable iff (sys_rst)
    reqValid && hitMap && req.write && !wpBit |-> memWe)
    else $error("mapped write not stored");

  chk_read_open: assert property (
    @(posedge clk) disable iff (sys_rst)
    reqValid && hitMap && !req.write |-> memRe)
    else $error("mapped read did not read the array");

  chk_data_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    reqValid && !isFetch && req.tt != `LSB_TT_CPU && dataIdle |-> !memRe && !memWe)
    else $error("array active on operand with data masked");

  chk_reg_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(ce && regWrite) |=> $stable(baseReg_r))
    else $error("register changed without a write");

  chk_user_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && ctlWrEn && !ctlSuper && !debugMode |=> $stable(baseReg_r))
    else $error("user mode write changed the register");

  chk_other_code: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && ctlCode != `LSB_CTL_CODE |=> !ctlRdValid && $stable(baseReg_r))
    else $error("other register code had an effect");

  chk_rd_valid: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && ctlRdEn && ctlCode == `LSB_CTL_CODE |=> ctlRdValid)
    else $error("register read not answered");

  chk_debug_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && regRead && debugMode |=> ctlRdata == $past(baseReg_r))
    else $error("debug read returned wrong value");

  chk_rdata_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && !memRe |=> $stable(resp.rdata))
    else $error("read data changed without a read");

  chk_ext_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    ce && !(reqValid && !hitMap) |=> $stable(extReq))
    else $error("forwarded request changed without a miss");

  chk_ce_freeze: assert property (
    @(posedge clk) disable iff (sys_rst)
    !ce |=> $stable(resp) && $stable(extValid) && $stable(baseReg_r))
    else $error("state moved while clock enable low");

  chk_long_lanes: assert property (
    @(posedge clk) disable iff (sys_rst)
    memWe && (req.size == `LSB_SIZE_LONG || req.size == `LSB_SIZE_LINE) |-> byteEn == 4'hF)
    else $error("longword write missed a lane");
endmodule
`default_nettype wire

/* verification/lsb_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lsb_core_model
  import lsb_pkg::*;
(
  output logic reqValid,
  output lsb_req_t req,
  output logic ctlWrEn,
  output logic ctlRdEn,
  output logic [11:0] ctlCode,
  output logic [31:0] ctlWdata,
  output logic ctlSuper,
  output logic debugMode
);
  initial
  begin
    reqValid = 1'b0;
    req = '0;
    ctlWrEn = 1'b0;
    ctlRdEn = 1'b0;
    ctlCode = 12'h000;
    ctlWdata = 32'h0000_0000;
    ctlSuper = 1'b0;
    debugMode = 1'b0;
  end
  // Core and debug requests share one port
  task automatic put(input lsb_req_t r);
    req = r;
    reqValid = 1'b1;
  endtask
  // Released request lines keep changing
  task automatic idle();
    reqValid = 1'b0;
    req = ~req;
    ctlWrEn = 1'b0;
    ctlRdEn = 1'b0;
    ctlWdata = ~ctlWdata;
  endtask
  // Register moves from user, supervisor or debug state
  task automatic ctl(input logic wr, input logic [11:0] c, input logic [31:0] d,
                     input logic s, input logic dbg);
    ctlWrEn = wr;
    ctlRdEn = ~wr;
    ctlCode = c;
    ctlWdata = d;
    ctlSuper = s;
    debugMode = dbg;
  endtask
endmodule
`default_nettype wire

/* verification/lsb_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module lsb_top_bench;
  import lsb_pkg::*;
  localparam logic [31:0] B = 32'h8000_0000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  wire logic reqValid, ctlWrEn, ctlRdEn, ctlSuper, debugMode, extValid, ctlRdValid;
  wire lsb_req_t req, extReq;
  wire lsb_resp_t resp;
  wire logic [11:0] ctlCode;
  wire logic [31:0] ctlWdata, ctlRdata;
  lsb_resp_t rs;
  lsb_req_t er;
  logic ev, cv;
  logic [31:0] cd;
  int n_tests = 0;
  int n_mismatch = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  lsb_core_model i_lsb_core_model (.reqValid(reqValid), .req(req), .ctlWrEn(ctlWrEn),
    .ctlRdEn(ctlRdEn), .ctlCode(ctlCode), .ctlWdata(ctlWdata), .ctlSuper(ctlSuper),
    .debugMode(debugMode));
  lsb_top i_lsb_top (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reqValid(reqValid), .req(req),
    .ctlWrEn(ctlWrEn), .ctlRdEn(ctlRdEn), .ctlCode(ctlCode), .ctlWdata(ctlWdata),
    .ctlSuper(ctlSuper), .debugMode(debugMode), .resp(resp), .extValid(extValid),
    .extReq(extReq), .ctlRdata(ctlRdata), .ctlRdValid(ctlRdValid));
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic rel();
    i_lsb_core_model.idle();
    @(negedge clk);
  endtask
  task automatic acc(input lsb_req_t r);
    i_lsb_core_model.put(r);
    @(negedge clk);
    rs = resp;
    ev = extValid;
    er = extReq;
  endtask
  task automatic rd(input logic [31:0] a, input logic c);
    acc('{a, 32'h0, 1'b0, 2'h0, 2'h0, 1'b1, c});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s);
    acc('{a, d, 1'b1, s, 2'h0, 1'b1, 1'b0});
  endtask
  task automatic map(input logic m);
    `CHK("done", m, rs.done)
    `CHK("extValid", ~m, ev)
  endtask
  task automatic cw(input logic [31:0] d, input logic s);
    i_lsb_core_model.ctl(1'b1, 12'hC04, d, s, 1'b0);
    @(negedge clk);
    rel();
  endtask
  task automatic cr(input logic [11:0] c, input logic dbg);
    i_lsb_core_model.ctl(1'b0, c, 32'h0, 1'b0, dbg);
    @(negedge clk);
    cd = ctlRdata;
    cv = ctlRdValid;
    rel();
  endtask
  task automatic t_reset();
    cr(12'hC04, 1'b1);
    `CHK("regReset", 32'h0, cd)
    rd(32'h0000_0004, 1'b0);
    map(1'b0);
    `CHK("extAddr", 32'h4, er.addr)
    rel();
    $display("t_reset done");
  endtask
  task automatic t_reg();
    cw(B | 32'hE1, 1'b1);
    cr(12'hC04, 1'b1);
    `CHK("reg", B | 32'h21, cd)
    cr(12'hC04, 1'b0);
    `CHK("regNoDbg", 32'h0, cd)
    `CHK("rdValid", 1'b1, cv)
    cw(32'h0, 1'b0);
    cr(12'hC04, 1'b1);
    `CHK("regUser", B | 32'h21, cd)
    cr(12'hC05, 1'b1);
    `CHK("rdValidOther", 1'b0, cv)
    $display("t_reg done");
  endtask
  task automatic t_rw();
    wr(B + 32'h10, 32'h1122_3344, 2'h0);
    map(1'b1);
    `CHK("noAlloc", 1'b1, rs.noAlloc)
    rd(B + 32'h10, 1'b0);
    map(1'b1);
    `CHK("rdBack", 32'h1122_3344, rs.rdata)
    wr(B + 32'h11, 32'h00AA_0000, 2'h1);
    wr(B + 32'h12, 32'h0000_BEEF, 2'h2);
    wr(B + 32'h1FC, 32'h5566_7788, 2'h0);
    rd(B + 32'h10, 1'b1);
    `CHK("lanes", 32'h11AA_BEEF, rs.rdata)
    `CHK("discard", 1'b1, rs.discard)
    rd(B + 32'h1FC, 1'b0);
    `CHK("lastWord", 32'h5566_7788, rs.rdata)
    rd(B + 32'h210, 1'b0);
    map(1'b0);
    `CHK("extReq", B + 32'h210, er.addr)
    rel();
    $display("t_rw done");
  endtask
  task automatic t_wp();
    cw(B | 32'h121, 1'b1);
    wr(B + 32'h10, 32'h0, 2'h0);
    `CHK("wpDone", 1'b1, rs.done)
    `CHK("wpErr", 1'b1, rs.err)
    rd(B + 32'h10, 1'b0);
    `CHK("wpKeep", 32'h11AA_BEEF, rs.rdata)
    rel();
    cw(32'hFFFF_FE21, 1'b1);
    wr(32'hFFFF_FE04, 32'hA5A5_5A5A, 2'h0);
    rd(32'hFFFF_FE04, 1'b0);
    `CHK("highBase", 32'hA5A5_5A5A, rs.rdata)
    rd(B + 32'h10, 1'b0);
    map(1'b0);
    rel();
    $display("t_wp done");
  endtask
  task automatic t_mask();
    for (int k = 0; k < 5; k++)
    begin
      cw(B | 32'h1 | (32'h2 << k), 1'b1);
      acc('{B, 32'h0, 1'b0, 2'h0, (k == 4) ? 2'h3 : 2'h0, k[1], k[0]});
      map(1'b0);
      rel();
    end
    cw(B | 32'h2B, 1'b1);
    rd(B, 1'b1);
    map(1'b1);
    rd(B, 1'b0);
    map(1'b0);
    rel();
    cw(B | 32'h35, 1'b1);
    rd(B, 1'b1);
    map(1'b0);
    rel();
    $display("t_mask done");
  endtask
  task automatic t_ce();
    ce = 1'b0;
    wr(B + 32'h10, 32'h0, 2'h0);
    `CHK("ceDone", 1'b0, rs.done)
    `CHK("ceExt", 1'b0, ev)
    ce = 1'b1;
    rd(B + 32'h10, 1'b0);
    map(1'b1);
    `CHK("ceKeep", 32'h11AA_BEEF, rs.rdata)
    rel();
    $display("t_ce done");
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_reg();
    t_rw();
    t_wp();
    t_mask();
    t_ce();
    give_verdict();
  end
endmodule
`default_nettype wire
